// ===== src/fpmap_pkg.sv
// Package for the field pair output mapper: function modes, field counts and timing.
// Assumes one 125 MHz clock domain; used by fpmap_top and the verification files.
package fpmap_pkg;

    // Function modes, chosen by a static configuration port
    typedef enum logic [3:0] {
        MODE_ONE_FIXED    = 4'h0,  // One function, one fixed field pair
        MODE_ONE_5FP      = 4'h1,  // One function, 5 pairs, overlapped change
        MODE_ONE_10FP     = 4'h2,  // One function, 10 pairs
        MODE_ONE_100FP    = 4'h3,  // One function, 100 pairs in one bank
        MODE_ONE_4F_FIXED = 4'h4,  // One function four field, fixed pair
        MODE_ONE_4F_SEL   = 4'h5,  // One function four field, 2 x 10 pairs
        MODE_ONE_MULTI    = 4'h6,  // One function, 10 banks x 10 pairs
        MODE_TWO_FIXED    = 4'h7,  // Two functions, one fixed pair each
        MODE_TWO_5FP      = 4'h8,  // Two functions, 5 pairs each, overlapped
        MODE_TWO_10FP     = 4'h9,  // Two functions, 10 pairs each
        MODE_TWO_4F       = 4'ha,  // Two functions four field, 50 pairs each
        MODE_TWO_MULTI    = 4'hb   // Two functions, 5 banks x 10 pairs each
    } mode_t;

    // Selection index width: up to 100 pairs
    localparam int unsigned SEL_W = 7;

    // Field pair counts per mode
    localparam logic [6:0] COUNT_1   = 7'h01;
    localparam logic [6:0] COUNT_5   = 7'h05;
    localparam logic [6:0] COUNT_10  = 7'h0a;
    localparam logic [6:0] COUNT_50  = 7'h32;
    localparam logic [6:0] COUNT_100 = 7'h64;

    // Bank counts
    localparam logic [3:0] BANKS_ONE_MULTI = 4'ha;
    localparam logic [3:0] BANKS_TWO_MULTI = 4'h5;
    localparam logic [3:0] BANKS_4F_SEL    = 4'h2;
    localparam logic [3:0] BANKS_SINGLE    = 4'h1;

    // Delay of second output pair in single-function modes
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned DELAY_US     = 100;
    localparam int unsigned DELAY_CYCLES = DELAY_US * CLK_MHZ;
    localparam int unsigned DELAY_W      = 16;

    // Overlapped monitoring window on a pair change, in cycles
    localparam int unsigned OVERLAP_NS     = 80;
    localparam int unsigned OVERLAP_CYCLES = (OVERLAP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned OVERLAP_W      = 8;

    // Reset values
    localparam logic [6:0] SEL_RESET = 7'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;

endpackage

// ===== src/fpmap_top.sv
// Field pair selection and violation-to-output mapping for a scanning safety sensor.
// Assumes violation inputs already evaluated per active field pair, synchronous to SYS_CLK.
`timescale 1ns/1ps

// Notes on behaviour
// - Single-pair modes ignore selection inputs
// - Five-pair modes change with overlapped monitoring
// - Ten-pair modes change at fixed moment
// - Hundred-pair mode: 100 pairs drive first outputs
// - Single function: ten pairs drive first outputs
// - Single-function modes delay second output switch-off
// - Two functions: own pairs, own outputs
// - Two functions select independently in 5FP and 10FP modes; 4F and multi copy A index to B
// - Single four field: one protective, three warning
// - Single four field: A index activates B
// - Single four field: B violation only indicates
// - Function A violation switches first outputs off
// - Two four field: B violation switches second off
// - Two four field: fifty pairs per function
// - Two four field: A index actuates B
// - Warning signals routed to chosen outputs
// - Single four field select: two sets ten
// - Single multi: ten banks of ten
// - Two multi: five banks of ten each
module fpmap_top (
    // Clock and reset
    input  wire logic             SYS_CLK,
    input  wire logic             RESETN,
    // Static configuration
    input  wire logic [3:0]       MODE,
    input  wire logic             WARN_ROUTE_A,      // 0: first output, 1: alternate
    input  wire logic             WARN_ROUTE_B,      // 0: first output, 1: alternate
    // Selection inputs from the machine control system
    input  wire logic [6:0]       SEL_PAIR_A,
    input  wire logic [3:0]       SEL_BANK_A,
    input  wire logic [6:0]       SEL_PAIR_B,
    input  wire logic [3:0]       SEL_BANK_B,
    input  wire logic             SEL_STROBE,        // Fixed changeover moment
    // Field evaluation results, per active pair
    input  wire logic             PF_VIOL_A,         // Protective field A violated
    input  wire logic             PF_VIOL_B,         // Protective field B violated
    input  wire logic             PF_VIOL_A_OLD,     // Old pair A during overlap
    input  wire logic             PF_VIOL_B_OLD,     // Old pair B during overlap
    input  wire logic [2:0]       WF_VIOL_A,         // Warning fields of A (three in single 4F)
    input  wire logic             WF_VIOL_B,
    // Safety and indication outputs
    output logic                  SAFETY_OUTPUT_PAIR_FIRST,
    output logic                  SAFETY_OUTPUT_PAIR_SECOND,
    output logic                  NONSAFE_INDICATION_OUTPUT,
    output logic                  FIRST_FUNCTION_WARNING_VIOLATION,
    output logic                  SECOND_FUNCTION_WARNING_VIOLATION,
    output logic                  WARN_OUT_A_ALT,
    output logic                  COMBINED_IO_OUTPUT_ONE,
    output logic                  WARN_OUT_B_ALT,
    // Active selection and status
    output logic [6:0]            ACTIVE_PAIR_A,
    output logic [3:0]            ACTIVE_BANK_A,
    output logic [6:0]            ACTIVE_PAIR_B,
    output logic [3:0]            ACTIVE_BANK_B,
    output logic                  OVERLAP_ACTIVE,
    output logic                  SELECT_FAULT
);

    // Mode decode
    fpmap_pkg::mode_t mode;            // Mode as enum
    logic             fixed_mode;      // One fixed pair per function
    logic             two_func;        // Independent second function
    logic             joint_sel;       // B follows A index
    logic             overlap_mode;    // Five-pair overlapped change
    logic [6:0]       pair_count;      // Pairs per bank
    logic [3:0]       bank_count;      // Banks per function

    // Selection state
    logic             sel_valid_a;     // A selection names a configured pair
    logic             sel_valid_b;     // B selection names a configured pair
    logic             sel_valid;       // Whole selection valid
    localparam int unsigned OVERLAP_W_L = fpmap_pkg::OVERLAP_W;
    logic [OVERLAP_W_L-1:0] overlap_cnt; // Overlap countdown
    logic [6:0]       prev_sel_a;      // Last sampled A index
    logic [6:0]       prev_sel_b;      // Last sampled B index

    // Output pair state
    logic             a_trip;          // First pair demand off
    logic             b_trip;          // Second pair demand off
    logic [fpmap_pkg::DELAY_W-1:0] delay_cnt; // Delay before second pair follows

    assign mode = fpmap_pkg::mode_t'(MODE);

    // Mode decode: counts and coupling per function mode
    always_comb begin
        fixed_mode   = 1'b0;
        two_func     = 1'b0;
        joint_sel    = 1'b0;
        overlap_mode = 1'b0;
        pair_count   = fpmap_pkg::COUNT_1;
        bank_count   = fpmap_pkg::BANKS_SINGLE;
        case (mode)
            fpmap_pkg::MODE_ONE_FIXED: begin
                fixed_mode = 1'b1;
            end
            fpmap_pkg::MODE_ONE_5FP: begin
                pair_count   = fpmap_pkg::COUNT_5;
                overlap_mode = 1'b1;
            end
            fpmap_pkg::MODE_ONE_10FP: begin
                pair_count = fpmap_pkg::COUNT_10;
            end
            fpmap_pkg::MODE_ONE_100FP: begin
                pair_count = fpmap_pkg::COUNT_100;
            end
            fpmap_pkg::MODE_ONE_4F_FIXED: begin
                fixed_mode = 1'b1;
                joint_sel  = 1'b1;
            end
            fpmap_pkg::MODE_ONE_4F_SEL: begin
                pair_count = fpmap_pkg::COUNT_10;
                bank_count = fpmap_pkg::BANKS_4F_SEL;
                joint_sel  = 1'b1;
            end
            fpmap_pkg::MODE_ONE_MULTI: begin
                pair_count = fpmap_pkg::COUNT_10;
                bank_count = fpmap_pkg::BANKS_ONE_MULTI;
            end
            fpmap_pkg::MODE_TWO_FIXED: begin
                fixed_mode = 1'b1;
                two_func   = 1'b1;
            end
            fpmap_pkg::MODE_TWO_5FP: begin
                pair_count   = fpmap_pkg::COUNT_5;
                two_func     = 1'b1;
                overlap_mode = 1'b1;
            end
            fpmap_pkg::MODE_TWO_10FP: begin
                pair_count = fpmap_pkg::COUNT_10;
                two_func   = 1'b1;
            end
            fpmap_pkg::MODE_TWO_4F: begin
                pair_count = fpmap_pkg::COUNT_50;
                two_func   = 1'b1;
                joint_sel  = 1'b1;
            end
            fpmap_pkg::MODE_TWO_MULTI: begin
                pair_count = fpmap_pkg::COUNT_10;
                bank_count = fpmap_pkg::BANKS_TWO_MULTI;
                two_func   = 1'b1;
                joint_sel  = 1'b1;
            end
            default: begin
                pair_count = 7'h00;                              // No pair: always a fault
            end
        endcase
    end

    // Validity of the selection inputs; fixed modes need no valid inputs
    always_comb begin
        sel_valid_a = fixed_mode ||
                      ((SEL_PAIR_A < pair_count) && (SEL_BANK_A < bank_count));
        sel_valid_b = fixed_mode || joint_sel || !two_func ||
                      ((SEL_PAIR_B < pair_count) && (SEL_BANK_B < bank_count));
        sel_valid   = sel_valid_a && sel_valid_b && (pair_count != 7'h00);
    end

    // Active selection, taken on the changeover strobe only; fixed modes stay at zero
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            ACTIVE_PAIR_A <= fpmap_pkg::SEL_RESET;
            ACTIVE_BANK_A <= fpmap_pkg::BANK_RESET;
            ACTIVE_PAIR_B <= fpmap_pkg::SEL_RESET;
            ACTIVE_BANK_B <= fpmap_pkg::BANK_RESET;
        end else if (fixed_mode) begin
            ACTIVE_PAIR_A <= fpmap_pkg::SEL_RESET;
            ACTIVE_BANK_A <= fpmap_pkg::BANK_RESET;
            ACTIVE_PAIR_B <= fpmap_pkg::SEL_RESET;
            ACTIVE_BANK_B <= fpmap_pkg::BANK_RESET;
        end else if (SEL_STROBE && sel_valid) begin
            ACTIVE_PAIR_A <= SEL_PAIR_A;
            ACTIVE_BANK_A <= SEL_BANK_A;
            if (joint_sel || !two_func) begin
                ACTIVE_PAIR_B <= SEL_PAIR_A;
                ACTIVE_BANK_B <= SEL_BANK_A;
            end else begin
                ACTIVE_PAIR_B <= SEL_PAIR_B;
                ACTIVE_BANK_B <= SEL_BANK_B;
            end
        end
    end

    // Previous index, to spot a pair change that opens an overlap window
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            prev_sel_a <= fpmap_pkg::SEL_RESET;
            prev_sel_b <= fpmap_pkg::SEL_RESET;
        end else begin
            prev_sel_a <= ACTIVE_PAIR_A;
            prev_sel_b <= ACTIVE_PAIR_B;
        end
    end

    // Overlap countdown: both old and new pair watched after a change
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            overlap_cnt <= '0;
        end else if (overlap_mode &&
                     ((prev_sel_a != ACTIVE_PAIR_A) || (prev_sel_b != ACTIVE_PAIR_B))) begin
            overlap_cnt <= OVERLAP_W_L'(fpmap_pkg::OVERLAP_CYCLES);
        end else if (overlap_cnt != '0) begin
            overlap_cnt <= overlap_cnt - 1'b1;
        end
    end

    // Trip demands: a violation of old or new pair during overlap counts
    always_comb begin
        a_trip = PF_VIOL_A || ((overlap_cnt != '0) && PF_VIOL_A_OLD) || !sel_valid;
        if (two_func) begin
            b_trip = PF_VIOL_B || ((overlap_cnt != '0) && PF_VIOL_B_OLD) || !sel_valid;
        end else begin
            b_trip = a_trip;
        end
    end

    // Second pair switch-off delay in single-function modes; zero in two-function modes
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            delay_cnt <= '0;
        end else if (two_func || !a_trip) begin
            delay_cnt <= '0;
        end else if (delay_cnt != fpmap_pkg::DELAY_W'(fpmap_pkg::DELAY_CYCLES)) begin
            delay_cnt <= delay_cnt + 1'b1;
        end
    end

    // First output pair: on only with no trip demand
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            SAFETY_OUTPUT_PAIR_FIRST <= 1'b0;
        end else begin
            SAFETY_OUTPUT_PAIR_FIRST <= !a_trip;
        end
    end

    // Second output pair: own function, or delayed copy of the first
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            SAFETY_OUTPUT_PAIR_SECOND <= 1'b0;
        end else if (two_func) begin
            SAFETY_OUTPUT_PAIR_SECOND <= !b_trip;
        end else if (!sel_valid) begin
            SAFETY_OUTPUT_PAIR_SECOND <= 1'b0;
        end else if (!a_trip) begin
            SAFETY_OUTPUT_PAIR_SECOND <= 1'b1;
        end else if (delay_cnt == fpmap_pkg::DELAY_W'(fpmap_pkg::DELAY_CYCLES)) begin
            SAFETY_OUTPUT_PAIR_SECOND <= 1'b0;
        end
    end

    // Non-safe indication: B protective field in single four field modes
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            NONSAFE_INDICATION_OUTPUT <= 1'b0;
        end else begin
            NONSAFE_INDICATION_OUTPUT <= joint_sel && !two_func && PF_VIOL_B;
        end
    end

    // Warning outputs; single four field mode watches three warning fields
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            FIRST_FUNCTION_WARNING_VIOLATION  <= 1'b0;
            SECOND_FUNCTION_WARNING_VIOLATION <= 1'b0;
            WARN_OUT_A_ALT                    <= 1'b0;
            COMBINED_IO_OUTPUT_ONE            <= 1'b0;
            WARN_OUT_B_ALT                    <= 1'b0;
        end else begin
            FIRST_FUNCTION_WARNING_VIOLATION  <= WF_VIOL_A[0] && !WARN_ROUTE_A;
            SECOND_FUNCTION_WARNING_VIOLATION <= (joint_sel && !two_func) ?
                                                 (WF_VIOL_A[1] | WF_VIOL_A[2] | WF_VIOL_B) :
                                                 WF_VIOL_B;
            WARN_OUT_A_ALT                    <= WF_VIOL_A[0] && WARN_ROUTE_A;
            COMBINED_IO_OUTPUT_ONE            <= WF_VIOL_B && !WARN_ROUTE_B;
            WARN_OUT_B_ALT                    <= WF_VIOL_B && WARN_ROUTE_B;
        end
    end

    // Status
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            OVERLAP_ACTIVE <= 1'b0;
            SELECT_FAULT   <= 1'b0;
        end else begin
            OVERLAP_ACTIVE <= (overlap_cnt != '0);
            SELECT_FAULT   <= !sel_valid;
        end
    end

endmodule

// ===== verification/field_pair_output_mapper_bench.sv
// Self-checking bench for the field pair output mapper.
// Assumes the control model drives the selection lines; the bench drives the rest.
`timescale 1ns/1ps
module field_pair_output_mapper_bench;
    // Clock, reset and configuration
    logic       SYS_CLK, RESETN, WARN_ROUTE_A, WARN_ROUTE_B;
    logic [3:0] MODE, SEL_BANK_A, SEL_BANK_B, act_ba, act_bb;
    // Selection lines and field results
    logic [6:0] SEL_PAIR_A, SEL_PAIR_B, act_pa, act_pb;
    logic       SEL_STROBE, PF_VIOL_A, PF_VIOL_B, PF_VIOL_A_OLD, PF_VIOL_B_OLD, WF_VIOL_B;
    logic [2:0] WF_VIOL_A;
    // Outputs of the mapper
    logic       first_on, second_on, nonsafe, warn_a, warn_b, warn_a_alt, io_one, warn_b_alt;
    logic       overlap, fault;
    int         fail_count, comparisons;

    // Free-running 125 MHz clock
    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    fpmap_top u_fpmap_top (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .MODE(MODE),
        .WARN_ROUTE_A(WARN_ROUTE_A), .WARN_ROUTE_B(WARN_ROUTE_B), .SEL_PAIR_A(SEL_PAIR_A),
        .SEL_BANK_A(SEL_BANK_A), .SEL_PAIR_B(SEL_PAIR_B), .SEL_BANK_B(SEL_BANK_B),
        .SEL_STROBE(SEL_STROBE), .PF_VIOL_A(PF_VIOL_A), .PF_VIOL_B(PF_VIOL_B),
        .PF_VIOL_A_OLD(PF_VIOL_A_OLD), .PF_VIOL_B_OLD(PF_VIOL_B_OLD), .WF_VIOL_A(WF_VIOL_A),
        .WF_VIOL_B(WF_VIOL_B), .SAFETY_OUTPUT_PAIR_FIRST(first_on),
        .SAFETY_OUTPUT_PAIR_SECOND(second_on), .NONSAFE_INDICATION_OUTPUT(nonsafe),
        .FIRST_FUNCTION_WARNING_VIOLATION(warn_a), .SECOND_FUNCTION_WARNING_VIOLATION(warn_b),
        .WARN_OUT_A_ALT(warn_a_alt), .COMBINED_IO_OUTPUT_ONE(io_one),
        .WARN_OUT_B_ALT(warn_b_alt), .ACTIVE_PAIR_A(act_pa), .ACTIVE_BANK_A(act_ba),
        .ACTIVE_PAIR_B(act_pb), .ACTIVE_BANK_B(act_bb), .OVERLAP_ACTIVE(overlap),
        .SELECT_FAULT(fault));

    sel_ctrl_model u_sel_ctrl_model (.clk(SYS_CLK), .pair_a(SEL_PAIR_A), .bank_a(SEL_BANK_A),
        .pair_b(SEL_PAIR_B), .bank_b(SEL_BANK_B), .strobe(SEL_STROBE));

    // Comparisons: bits and indices, counted and reported at once
    task automatic check1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check7(input string what, input logic [6:0] exp, input logic [6:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pair count and bank count of a mode; zero pairs marks a fixed mode
    function automatic logic [10:0] limits(input logic [3:0] m);
        case (m)
            fpmap_pkg::MODE_ONE_5FP, fpmap_pkg::MODE_TWO_5FP:
                return {fpmap_pkg::COUNT_5, fpmap_pkg::BANKS_SINGLE};
            fpmap_pkg::MODE_ONE_10FP, fpmap_pkg::MODE_TWO_10FP:
                return {fpmap_pkg::COUNT_10, fpmap_pkg::BANKS_SINGLE};
            fpmap_pkg::MODE_ONE_100FP: return {fpmap_pkg::COUNT_100, fpmap_pkg::BANKS_SINGLE};
            fpmap_pkg::MODE_ONE_4F_SEL: return {fpmap_pkg::COUNT_10, fpmap_pkg::BANKS_4F_SEL};
            fpmap_pkg::MODE_ONE_MULTI: return {fpmap_pkg::COUNT_10, fpmap_pkg::BANKS_ONE_MULTI};
            fpmap_pkg::MODE_TWO_4F: return {fpmap_pkg::COUNT_50, fpmap_pkg::BANKS_SINGLE};
            fpmap_pkg::MODE_TWO_MULTI: return {fpmap_pkg::COUNT_10, fpmap_pkg::BANKS_TWO_MULTI};
            default: return 11'h000;
        endcase
    endfunction
    function automatic logic valid_sel(input logic [3:0] m, input logic [6:0] p,
                                       input logic [3:0] b);
        logic [10:0] l;
        l = limits(m);
        return (l[10:4] == 7'h00) || (p < l[10:4] && b < l[3:0]);
    endfunction

    // Wait whole cycles, landing on falling edges
    task automatic cycles(input int n);
        repeat (n) @(negedge SYS_CLK);
    endtask

    // One selection: fault flag, then the indices that become active
    task automatic sel_case(input logic [3:0] m, input logic [6:0] pa, input logic [3:0] ba,
                            input logic [6:0] pb);
        logic split;
        logic fixed;
        split = (m == fpmap_pkg::MODE_TWO_FIXED) || (m == fpmap_pkg::MODE_TWO_5FP)
                || (m == fpmap_pkg::MODE_TWO_10FP);
        fixed = (limits(m) == 11'h000);
        MODE = m;
        u_sel_ctrl_model.pick(pa, ba, pb, ba);
        check1("select fault", !valid_sel(m, pa, ba), fault);
        if (valid_sel(m, pa, ba)) begin
            check7("active pair a", fixed ? 7'h00 : pa, act_pa);
            check7("active bank a", fixed ? 7'h00 : {3'h0, ba}, {3'h0, act_ba});
            check7("active pair b", fixed ? 7'h00 : (split ? pb : pa), act_pb);
        end
    endtask

    // Closing verdict
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog sized well above the long delay scenario
    initial begin
        #(8 * 30000);
        fail_count++;
        results();
    end

    // Main sequence
    initial begin
        logic [6:0] p;
        {RESETN, MODE, WARN_ROUTE_A, WARN_ROUTE_B, WF_VIOL_A, WF_VIOL_B} = '0;
        {PF_VIOL_A, PF_VIOL_B, PF_VIOL_A_OLD, PF_VIOL_B_OLD} = '0;
        fail_count = 0;
        comparisons = 0;
        void'($urandom(32'hb45c));
        cycles(4);
        RESETN = 1'b1;
        sel_case(fpmap_pkg::MODE_ONE_FIXED, 7'h05, 4'h3, 7'h02);
        sel_case(fpmap_pkg::MODE_TWO_FIXED, 7'h05, 4'h3, 7'h02);
        sel_case(fpmap_pkg::MODE_ONE_4F_FIXED, 7'h05, 4'h3, 7'h02);
        sel_case(fpmap_pkg::MODE_TWO_5FP, 7'h04, 4'h0, 7'h02);
        // Random selections, some out of range, with random trips
        for (int i = 0; i < 24; i++) begin
            p = 7'($urandom % 12);
            PF_VIOL_A = 1'($urandom % 2);
            sel_case(fpmap_pkg::MODE_ONE_10FP, p, 4'h0, 7'h00);
            check1("first pair", valid_sel(MODE, p, 4'h0) && !PF_VIOL_A, first_on);
        end
        PF_VIOL_A = 1'b0;
        // Boundary indices and banks of the 100-pair, multi and four field select modes; split B index in two-function 10-pair mode
        sel_case(fpmap_pkg::MODE_ONE_100FP, 7'h63, 4'h0, 7'h00);
        sel_case(fpmap_pkg::MODE_ONE_100FP, 7'h64, 4'h0, 7'h00);
        sel_case(fpmap_pkg::MODE_ONE_MULTI, 7'h09, 4'h9, 7'h00);
        sel_case(fpmap_pkg::MODE_ONE_MULTI, 7'h09, 4'ha, 7'h00);
        sel_case(fpmap_pkg::MODE_TWO_MULTI, 7'h03, 4'h4, 7'h00);
        sel_case(fpmap_pkg::MODE_TWO_MULTI, 7'h03, 4'h5, 7'h00);
        sel_case(fpmap_pkg::MODE_TWO_10FP, 7'h04, 4'h0, 7'h07);
        sel_case(fpmap_pkg::MODE_ONE_4F_SEL, 7'h09, 4'h2, 7'h00);
        sel_case(fpmap_pkg::MODE_ONE_4F_SEL, 7'h09, 4'h1, 7'h00);
        // Second field only indicates in single four field mode, trips second pair in two four field mode
        PF_VIOL_B = 1'b1;
        cycles(2);
        check1("nonsafe indication", 1'b1, nonsafe);
        check1("first pair", 1'b1, first_on);
        PF_VIOL_B = 1'b0;
        sel_case(fpmap_pkg::MODE_TWO_4F, 7'h32, 4'h0, 7'h00);
        sel_case(fpmap_pkg::MODE_TWO_4F, 7'h31, 4'h0, 7'h00);
        check1("second pair", 1'b1, second_on);
        PF_VIOL_B = 1'b1;
        {WF_VIOL_A, WARN_ROUTE_A, WF_VIOL_B} = {3'h1, 1'b1, 1'b1};
        cycles(2);
        check1("second pair", 1'b0, second_on);
        check1("warning a alternate", 1'b1, warn_a_alt);
        check1("warning b primary", 1'b1, io_one);
        check1("warning a", 1'b0, warn_a);
        check1("warning b", 1'b1, warn_b);
        {PF_VIOL_B, WF_VIOL_A, WF_VIOL_B} = '0;
        // Overlapped change: the old pair still trips the first output pair
        sel_case(fpmap_pkg::MODE_ONE_5FP, 7'h03, 4'h0, 7'h00);
        cycles(12);
        sel_case(fpmap_pkg::MODE_ONE_5FP, 7'h01, 4'h0, 7'h00);
        cycles(2);
        check1("overlap", 1'b1, overlap);
        PF_VIOL_A_OLD = 1'b1;
        cycles(2);
        check1("first pair in overlap", 1'b0, first_on);
        PF_VIOL_A_OLD = 1'b0;
        cycles(12);
        check1("overlap end", 1'b0, overlap);
        // Long trip: second pair goes off only after its delay
        sel_case(fpmap_pkg::MODE_ONE_10FP, 7'h02, 4'h0, 7'h00);
        PF_VIOL_A = 1'b1;
        cycles(12000);
        check1("second pair held", 1'b1, second_on);
        cycles(600);
        check1("second pair delayed off", 1'b0, second_on);
        PF_VIOL_A = 1'b0;
        results();
    end
endmodule

// ===== verification/fpmap_properties.sv
// Concurrent checks on the ports of the field pair output mapper.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module fpmap_checker (
    // Clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RESETN,
    // Inputs watched as causes
    input  wire logic [3:0] MODE,
    input  wire logic       WARN_ROUTE_A,
    input  wire logic [6:0] SEL_PAIR_A,
    input  wire logic [3:0] SEL_BANK_A,
    input  wire logic       SEL_STROBE,
    input  wire logic       PF_VIOL_A,
    input  wire logic       PF_VIOL_B,
    input  wire logic [2:0] WF_VIOL_A,
    // Outputs watched as effects
    input  wire logic       SAFETY_OUTPUT_PAIR_FIRST,
    input  wire logic       SAFETY_OUTPUT_PAIR_SECOND,
    input  wire logic       NONSAFE_INDICATION_OUTPUT,
    input  wire logic       WARN_OUT_A_ALT,
    input  wire logic [6:0] ACTIVE_PAIR_A,
    input  wire logic [6:0] ACTIVE_PAIR_B,
    input  wire logic       OVERLAP_ACTIVE,
    input  wire logic       SELECT_FAULT
);
    // One domain, so clock and disable are declared once
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // Reset must leave the safety outputs off, so reset itself is no disable here
    reset_outputs_off_a: assert property (disable iff (1'b0) !RESETN |=>
        !SAFETY_OUTPUT_PAIR_FIRST && !SAFETY_OUTPUT_PAIR_SECOND && !SELECT_FAULT)
        else $error("safety outputs on after reset");
    a_trip_off_a: assert property (PF_VIOL_A |=> !SAFETY_OUTPUT_PAIR_FIRST)
        else $error("first pair stayed on during a trip");
    fault_holds_off_a: assert property (SELECT_FAULT |->
        !SAFETY_OUTPUT_PAIR_FIRST && !SAFETY_OUTPUT_PAIR_SECOND)
        else $error("safety output on with a selection fault");
    bad_select_refused_a: assert property (MODE == fpmap_pkg::MODE_ONE_10FP
        && SEL_STROBE && SEL_PAIR_A >= 7'h0a |=> SELECT_FAULT && $stable(ACTIVE_PAIR_A))
        else $error("out of range selection taken");
    fixed_ignores_a: assert property (MODE == fpmap_pkg::MODE_ONE_FIXED && $stable(MODE)
        && SEL_STROBE |=> $stable(ACTIVE_PAIR_A))
        else $error("fixed mode followed the selection lines");
    select_taken_a: assert property (MODE == fpmap_pkg::MODE_ONE_10FP && SEL_STROBE
        && SEL_PAIR_A < 7'h0a && SEL_BANK_A == 4'h0 |=> ACTIVE_PAIR_A == $past(SEL_PAIR_A))
        else $error("valid selection not taken");
    joint_copy_a: assert property (MODE == fpmap_pkg::MODE_TWO_4F && SEL_STROBE
        && SEL_PAIR_A < 7'h32 && SEL_BANK_A == 4'h0 |=> ACTIVE_PAIR_B == $past(SEL_PAIR_A))
        else $error("second function index not copied");
    b_indicates_a: assert property ((MODE == fpmap_pkg::MODE_ONE_4F_FIXED
        || MODE == fpmap_pkg::MODE_ONE_4F_SEL) && PF_VIOL_B |=> NONSAFE_INDICATION_OUTPUT)
        else $error("indication missing for second field");
    b_trip_off_a: assert property (MODE == fpmap_pkg::MODE_TWO_4F && PF_VIOL_B
        |=> !SAFETY_OUTPUT_PAIR_SECOND)
        else $error("second pair stayed on during a trip");
    overlap_start_a: assert property (MODE == fpmap_pkg::MODE_ONE_5FP
        && $changed(ACTIVE_PAIR_A) |-> ##2 OVERLAP_ACTIVE)
        else $error("no overlap after a pair change");
    warn_route_a: assert property (MODE == fpmap_pkg::MODE_TWO_4F && WF_VIOL_A[0]
        && WARN_ROUTE_A |=> WARN_OUT_A_ALT)
        else $error("warning not on alternate output");
endmodule

bind fpmap_top fpmap_checker u_fpmap_checker (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .MODE(MODE), .WARN_ROUTE_A(WARN_ROUTE_A),
    .SEL_PAIR_A(SEL_PAIR_A), .SEL_BANK_A(SEL_BANK_A), .SEL_STROBE(SEL_STROBE),
    .PF_VIOL_A(PF_VIOL_A), .PF_VIOL_B(PF_VIOL_B), .WF_VIOL_A(WF_VIOL_A),
    .SAFETY_OUTPUT_PAIR_FIRST(SAFETY_OUTPUT_PAIR_FIRST),
    .SAFETY_OUTPUT_PAIR_SECOND(SAFETY_OUTPUT_PAIR_SECOND),
    .NONSAFE_INDICATION_OUTPUT(NONSAFE_INDICATION_OUTPUT), .WARN_OUT_A_ALT(WARN_OUT_A_ALT),
    .ACTIVE_PAIR_A(ACTIVE_PAIR_A), .ACTIVE_PAIR_B(ACTIVE_PAIR_B),
    .OVERLAP_ACTIVE(OVERLAP_ACTIVE), .SELECT_FAULT(SELECT_FAULT));

// ===== verification/sel_ctrl_model.sv
// Behavioural model of the machine control system that picks the active field pair.
// Assumes the mapper samples selection levels and the strobe on the rising clock edge.
`timescale 1ns/1ps
module sel_ctrl_model (
    // Clock of the mapper
    input  wire logic       clk,
    // Selection lines toward the mapper
    output logic      [6:0] pair_a,
    output logic      [3:0] bank_a,
    output logic      [6:0] pair_b,
    output logic      [3:0] bank_b,
    output logic            strobe
);
    // Idle at power-up: index zero, no changeover request
    initial begin
        {pair_a, bank_a, pair_b, bank_b, strobe} = '0;
    end

    // Levels change off the sampling edge and stay put afterwards, as a real
    // controller holds its outputs; the strobe lasts exactly one rising edge
    task automatic pick(input logic [6:0] pa, input logic [3:0] ba,
                        input logic [6:0] pb, input logic [3:0] bb);
        @(negedge clk);
        {pair_a, bank_a, pair_b, bank_b, strobe} <= {pa, ba, pb, bb, 1'b1};
        @(negedge clk);
        strobe <= 1'b0;
    endtask
endmodule
